// [rtl/sdimx_pkg.sv]
package sdimx_pkg;

  // ----------------------------------------------------------------
  // Pin widths and pin positions
  // ----------------------------------------------------------------
  localparam int PIN_W      = 18;
  localparam int LSB_BUS32  = 2;
  localparam int LSB_BUS16  = 1;
  localparam int AP_OFFSET  = 10;
  localparam int ROW_BASE   = 11;
  localparam int COL_BASE   = 8;
  localparam int ADDR_W     = 32;
  localparam int MODE_W     = 16;
  localparam int MODE_DATA_W = 12;
  localparam logic [1:0] WIDTH_SEL_MAX = 2'h2;
  localparam logic [3:0] REFRESH_TOTAL = 4'h8;

  // ----------------------------------------------------------------
  // Idle cycle tables for the timing fields
  // ----------------------------------------------------------------
  localparam logic [3:0] PRE_IDLE [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
  localparam logic [3:0] REF_IDLE [4] = '{4'h3, 4'h4, 4'h6, 4'h9};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDIMX_CMD_NOP   = 3'h0,
    SDIMX_CMD_ACT   = 3'h1,
    SDIMX_CMD_READ  = 3'h2,
    SDIMX_CMD_WRITE = 3'h3,
    SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD  = 3'h4,
    SDIMX_CMD_REF   = 3'h5,
    SDIMX_CMD_MRS   = 3'h6
  } sdimx_cmd_t;

  typedef enum logic [2:0] {
    SDIMX_ST_IDLE  = 3'h0,
    SDIMX_ST_PRECHARGE_ALL_BANKS_CMD  = 3'h1,
    SDIMX_ST_PWAIT = 3'h2,
    SDIMX_ST_REF   = 3'h3,
    SDIMX_ST_RWAIT = 3'h4,
    SDIMX_ST_MRS   = 3'h5
  } sdimx_state_t;

  typedef struct packed {
    logic              area2_select_n;
    logic              area3_select_n;
    logic              ras_n;
    logic              cas_n;
    logic              read_write_strobe_n;
    logic [PIN_W-1:0]  addr;
  } sdimx_pins_t;

  typedef struct packed {
    logic              area3_sdram;
    logic              area2_sdram;
    logic              bus32;
    logic [1:0]        row_sel;
    logic [1:0]        col_sel;
    logic              auto_precharge;
    logic [1:0]        precharge_idle_field;
    logic [1:0]        refresh_idle_field;
  } sdimx_cfg_t;

  typedef struct packed {
    sdimx_state_t      state;
    logic [3:0]        wait_cnt;
    logic [3:0]        ref_cnt;
    logic              init_done;
    logic              init_ack;
    logic [MODE_W-1:0] mode_addr;
    sdimx_cmd_t        last_cmd;
    sdimx_pins_t       pins;
  } sdimx_regs_t;

  localparam sdimx_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};

endpackage : sdimx_pkg

// [rtl/sdimx_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

module sdimx_ctrl (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire sdimx_pkg::sdimx_cfg_t         cfg,
  input  wire logic                          mode_req,
  input  wire logic [sdimx_pkg::ADDR_W-1:0]  mode_addr,
  output logic                               mode_ack,
  input  wire logic                          cmd_valid,
  input  wire sdimx_pkg::sdimx_cmd_t         cmd_kind,
  input  wire logic                          cmd_area3,
  input  wire logic [sdimx_pkg::ADDR_W-1:0]  cmd_addr,
  output logic                               cmd_ready,
  output logic                               init_done,
  output var sdimx_pkg::sdimx_pins_t         pins
);

  // ----------------------------------------------------------------
  // Address multiplexer
  // ----------------------------------------------------------------
  function automatic logic [sdimx_pkg::PIN_W-1:0] mux_addr(
    input logic [sdimx_pkg::ADDR_W-1:0] a,
    input logic                         row_phase,
    input sdimx_pkg::sdimx_cfg_t        c
  );
    int lsb;
    int rw;
    int cw;
    logic [sdimx_pkg::PIN_W-1:0] r;
    lsb = c.bus32 ? sdimx_pkg::LSB_BUS32 : sdimx_pkg::LSB_BUS16;
    rw  = sdimx_pkg::ROW_BASE + int'(c.row_sel);
    cw  = sdimx_pkg::COL_BASE + int'(c.col_sel);
    r   = '0;
    for (int p = 0; p < sdimx_pkg::PIN_W; p++) begin
      if (p >= lsb && p < lsb + rw + 2) begin
        if (row_phase || p >= lsb + rw) begin
          r[p] = a[p + cw];
        end else if (p == lsb + sdimx_pkg::AP_OFFSET) begin
          r[p] = c.auto_precharge;
        end else begin
          r[p] = a[p];
        end
      end
    end
    return r;
  endfunction : mux_addr

  // ----------------------------------------------------------------
  // Command encoding onto the strobes
  // ----------------------------------------------------------------
  function automatic sdimx_pkg::sdimx_pins_t drive(
    input sdimx_pkg::sdimx_cmd_t     k,
    input logic                      a3,
    input logic [sdimx_pkg::PIN_W-1:0] adr
  );
    sdimx_pkg::sdimx_pins_t o;
    o = sdimx_pkg::PINS_IDLE;
    o.addr = adr;
    if (k != sdimx_pkg::SDIMX_CMD_NOP) begin
      o.area3_select_n = !a3;
      o.area2_select_n = a3;
    end
    unique case (k)
      sdimx_pkg::SDIMX_CMD_NOP: begin
        o.addr = '0;
      end
      sdimx_pkg::SDIMX_CMD_ACT: begin
        o.ras_n = 1'b0;
      end
      sdimx_pkg::SDIMX_CMD_READ: begin
        o.cas_n = 1'b0;
      end
      sdimx_pkg::SDIMX_CMD_WRITE: begin
        o.cas_n = 1'b0;
        o.read_write_strobe_n = 1'b0;
      end
      sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD: begin
        o.ras_n = 1'b0;
        o.read_write_strobe_n = 1'b0;
      end
      sdimx_pkg::SDIMX_CMD_REF: begin
        o.ras_n = 1'b0;
        o.cas_n = 1'b0;
      end
      sdimx_pkg::SDIMX_CMD_MRS: begin
        o.ras_n = 1'b0;
        o.cas_n = 1'b0;
        o.read_write_strobe_n = 1'b0;
      end
      default: begin
        o = sdimx_pkg::PINS_IDLE;
      end
    endcase
    return o;
  endfunction : drive

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  sdimx_pkg::sdimx_regs_t  st;
  sdimx_pkg::sdimx_regs_t  next_st;
  logic                    area_ok;
  logic [sdimx_pkg::PIN_W-1:0] all_ap;
  logic [sdimx_pkg::PIN_W-1:0] mode_pins;

  // Area 2 is only usable as SDRAM when area 3 is SDRAM as well.
  assign area_ok = cmd_area3 ? cfg.area3_sdram : (cfg.area2_sdram && cfg.area3_sdram);
  assign cmd_ready = st.init_done && st.state == sdimx_pkg::SDIMX_ST_IDLE;
  assign init_done = st.init_done;
  assign mode_ack  = st.init_ack;
  assign pins      = st.pins;

  always_comb begin
    all_ap = '0;
    all_ap[(cfg.bus32 ? sdimx_pkg::LSB_BUS32 : sdimx_pkg::LSB_BUS16)
           + sdimx_pkg::AP_OFFSET] = 1'b1;
    mode_pins = '0;
    // Only the offset inside the mode window reaches the pins; the window base is dropped.
    mode_pins[sdimx_pkg::MODE_DATA_W-1:0] =
      st.mode_addr[sdimx_pkg::MODE_DATA_W-1:0];
  end

  always_comb begin
    next_st = st;
    next_st.init_ack = 1'b0;
    next_st.last_cmd = sdimx_pkg::SDIMX_CMD_NOP;
    next_st.pins = sdimx_pkg::PINS_IDLE;
    unique case (st.state)
      sdimx_pkg::SDIMX_ST_IDLE: begin
        if (mode_req) begin
          next_st.mode_addr = mode_addr[sdimx_pkg::MODE_W-1:0];
          next_st.state = sdimx_pkg::SDIMX_ST_PRECHARGE_ALL_BANKS_CMD;
        end else if (cmd_valid && st.init_done && area_ok) begin
          // Each read or write is one column command: burst length one.
          next_st.last_cmd = cmd_kind;
          next_st.pins = drive(cmd_kind, cmd_area3,
                               mux_addr(cmd_addr, cmd_kind == sdimx_pkg::SDIMX_CMD_ACT, cfg));
        end
      end
      sdimx_pkg::SDIMX_ST_PRECHARGE_ALL_BANKS_CMD: begin
        next_st.last_cmd = sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD;
        next_st.pins = drive(sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD, 1'b1, all_ap);
        next_st.wait_cnt = sdimx_pkg::PRE_IDLE[cfg.precharge_idle_field];
        next_st.ref_cnt = '0;
        next_st.state = sdimx_pkg::SDIMX_ST_PWAIT;
      end
      sdimx_pkg::SDIMX_ST_PWAIT, sdimx_pkg::SDIMX_ST_RWAIT: begin
        next_st.wait_cnt = st.wait_cnt - 4'h1;
        if (st.wait_cnt == 4'h1) begin
          next_st.state = (st.ref_cnt == sdimx_pkg::REFRESH_TOTAL)
                        ? sdimx_pkg::SDIMX_ST_MRS : sdimx_pkg::SDIMX_ST_REF;
        end
      end
      sdimx_pkg::SDIMX_ST_REF: begin
        next_st.last_cmd = sdimx_pkg::SDIMX_CMD_REF;
        next_st.pins = drive(sdimx_pkg::SDIMX_CMD_REF, 1'b1, '0);
        next_st.ref_cnt = st.ref_cnt + 4'h1;
        next_st.wait_cnt = sdimx_pkg::REF_IDLE[cfg.refresh_idle_field];
        next_st.state = sdimx_pkg::SDIMX_ST_RWAIT;
      end
      sdimx_pkg::SDIMX_ST_MRS: begin
        next_st.last_cmd = sdimx_pkg::SDIMX_CMD_MRS;
        next_st.pins = drive(sdimx_pkg::SDIMX_CMD_MRS, 1'b1, mode_pins);
        next_st.init_done = 1'b1;
        next_st.init_ack = 1'b1;
        next_st.state = sdimx_pkg::SDIMX_ST_IDLE;
      end
      default: begin
        next_st.state = sdimx_pkg::SDIMX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '{state: sdimx_pkg::SDIMX_ST_IDLE, wait_cnt: '0, ref_cnt: '0,
              init_done: 1'b0, init_ack: 1'b0, mode_addr: '0,
              last_cmd: sdimx_pkg::SDIMX_CMD_NOP, pins: sdimx_pkg::PINS_IDLE};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_precharge_all_banks_cmd_to_ref_two;
    @(posedge clk_sys) disable iff (rst)
    (st.last_cmd == sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD && cfg.precharge_idle_field == 2'h1)
      |=> (st.last_cmd == sdimx_pkg::SDIMX_CMD_NOP)[*2]
          ##1 st.last_cmd == sdimx_pkg::SDIMX_CMD_REF;
  endproperty
  a_precharge_all_banks_cmd_to_ref_two: assert property (p_precharge_all_banks_cmd_to_ref_two) else $error("precharge gap wrong");

  property p_ref_gap_six;
    @(posedge clk_sys) disable iff (rst)
    (st.last_cmd == sdimx_pkg::SDIMX_CMD_REF && cfg.refresh_idle_field == 2'h2)
      |=> (st.last_cmd == sdimx_pkg::SDIMX_CMD_NOP)[*6]
          ##1 st.last_cmd != sdimx_pkg::SDIMX_CMD_NOP;
  endproperty
  a_ref_gap_six: assert property (p_ref_gap_six) else $error("refresh gap wrong");

  property p_seq_start;
    @(posedge clk_sys) disable iff (rst)
    (mode_req && st.state == sdimx_pkg::SDIMX_ST_IDLE)
      |-> ##2 st.last_cmd == sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD && !st.pins.area3_select_n;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence did not start");

  property p_eight_refs;
    @(posedge clk_sys) disable iff (rst)
    st.last_cmd == sdimx_pkg::SDIMX_CMD_MRS |-> $past(st.ref_cnt) == sdimx_pkg::REFRESH_TOTAL;
  endproperty
  a_eight_refs: assert property (p_eight_refs) else $error("refresh count wrong");

  property p_ack_after_mrs;
    @(posedge clk_sys) disable iff (rst)
    mode_ack |-> st.last_cmd == sdimx_pkg::SDIMX_CMD_MRS && init_done;
  endproperty
  a_ack_after_mrs: assert property (p_ack_after_mrs) else $error("early acknowledge");

  property p_no_early_cmd;
    @(posedge clk_sys) disable iff (rst)
    !init_done |-> !(st.last_cmd inside {sdimx_pkg::SDIMX_CMD_ACT,
                     sdimx_pkg::SDIMX_CMD_READ, sdimx_pkg::SDIMX_CMD_WRITE});
  endproperty
  a_no_early_cmd: assert property (p_no_early_cmd) else $error("command before mode set");

  property p_mrs_data;
    @(posedge clk_sys) disable iff (rst)
    st.last_cmd == sdimx_pkg::SDIMX_CMD_MRS
      |-> st.pins.addr[sdimx_pkg::MODE_DATA_W-1:0] == st.mode_addr[sdimx_pkg::MODE_DATA_W-1:0]
          && st.pins.addr[sdimx_pkg::PIN_W-1:sdimx_pkg::MODE_DATA_W] == '0
          && !st.pins.read_write_strobe_n;
  endproperty
  a_mrs_data: assert property (p_mrs_data) else $error("mode data wrong");

  property p_col_ap;
    @(posedge clk_sys) disable iff (rst)
    (cmd_ready && cmd_valid && area_ok && !mode_req && cfg.bus32
     && cmd_kind inside {sdimx_pkg::SDIMX_CMD_READ, sdimx_pkg::SDIMX_CMD_WRITE})
      |=> st.pins.addr[sdimx_pkg::LSB_BUS32 + sdimx_pkg::AP_OFFSET] == $past(cfg.auto_precharge);
  endproperty
  a_col_ap: assert property (p_col_ap) else $error("precharge pin wrong");

  property p_area2_gated;
    @(posedge clk_sys) disable iff (rst)
    !st.pins.area2_select_n |-> $past(cfg.area2_sdram && cfg.area3_sdram);
  endproperty
  a_area2_gated: assert property (p_area2_gated) else $error("area 2 used alone");

  c_init_done: cover property (@(posedge clk_sys) disable iff (rst) $rose(init_done));
  c_read: cover property (@(posedge clk_sys) disable iff (rst)
    st.last_cmd == sdimx_pkg::SDIMX_CMD_READ);
  c_area2_write: cover property (@(posedge clk_sys) disable iff (rst)
    st.last_cmd == sdimx_pkg::SDIMX_CMD_WRITE && !st.pins.area2_select_n);

endmodule : sdimx_ctrl

`default_nettype wire

// [verif/sdimx_sdram_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sdimx_sdram_model (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire sdimx_pkg::sdimx_pins_t       pins,
  output logic [sdimx_pkg::PIN_W-1:0]       mode_reg,
  output logic [3:0]                        ref_count,
  output logic                              misorder
);
  logic       ready;
  logic [2:0] strobe;

  assign strobe = {pins.ras_n, pins.cas_n, pins.read_write_strobe_n};

  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  // Any access command seen before the mode register is set marks a fault.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= '0;
      ref_count <= '0;
      misorder <= 1'b0;
      ready <= 1'b0;
    end else if (!pins.area3_select_n) begin
      case (strobe)
        3'b010: ref_count <= '0;
        3'b001: ref_count <= ref_count + 4'h1;
        3'b000: begin
          mode_reg <= pins.addr;
          ready <= 1'b1;
        end
        3'b111: ;
        default: misorder <= misorder | ~ready;
      endcase
    end else if (!pins.area2_select_n) begin
      misorder <= misorder | ~ready;
    end
  end

endmodule : sdimx_sdram_model

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic                        clk_sys = 1'b0;
  logic                        rst = 1'b1;
  sdimx_pkg::sdimx_cfg_t       cfg = '0;
  logic                        mode_req = 1'b0;
  logic [31:0]                 mode_addr = '0;
  logic                        cmd_valid = 1'b0;
  sdimx_pkg::sdimx_cmd_t       cmd_kind = sdimx_pkg::SDIMX_CMD_NOP;
  logic                        cmd_area3 = 1'b1;
  logic [31:0]                 cmd_addr = '0;
  logic                        mode_ack;
  logic                        cmd_ready;
  logic                        init_done;
  sdimx_pkg::sdimx_pins_t      pins;
  logic [17:0]                 mode_reg;
  logic [3:0]                  ref_count;
  logic                        misorder;
  logic [4:0]                  seen;
  int                          bad_count = 0;
  int                          check_count = 0;
  logic [3:0]                  pre_idle [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
  logic [3:0]                  ref_idle [4] = '{4'h3, 4'h4, 4'h6, 4'h9};
  logic [15:0]                 mode_pat [8] = '{16'h0880, 16'h08c0, 16'h0080, 16'h00c0,
                                                16'h0440, 16'h0460, 16'h0040, 16'h0060};
  // Base of the mode window; the pattern is the offset inside it.
  localparam logic [31:0]      MODE_WINDOW = 32'hfec1_5000;

  always #10 clk_sys = ~clk_sys;

  assign seen = {pins.area2_select_n, pins.area3_select_n, pins.ras_n, pins.cas_n,
                 pins.read_write_strobe_n};

  sdimx_ctrl u_sdimx_ctrl (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .mode_req(mode_req),
    .mode_addr(mode_addr), .mode_ack(mode_ack), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_area3(cmd_area3), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
    .init_done(init_done), .pins(pins));

  sdimx_sdram_model u_sdimx_sdram_model (.clk_sys(clk_sys), .rst(rst), .pins(pins),
    .mode_reg(mode_reg), .ref_count(ref_count), .misorder(misorder));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [4:0] strb(input sdimx_pkg::sdimx_cmd_t k);
    case (k)
      sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD:  strb = 5'h12;
      sdimx_pkg::SDIMX_CMD_REF:   strb = 5'h11;
      sdimx_pkg::SDIMX_CMD_MRS:   strb = 5'h10;
      sdimx_pkg::SDIMX_CMD_ACT:   strb = 5'h13;
      sdimx_pkg::SDIMX_CMD_READ:  strb = 5'h15;
      sdimx_pkg::SDIMX_CMD_WRITE: strb = 5'h14;
      default:                    strb = 5'h1f;
    endcase
  endfunction : strb

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("idle strobes", 32'h1f, 32'(seen));
    chk("idle address", 32'h0, 32'(pins.addr));
    chk("status", 32'h0, {29'h0, init_done, cmd_ready, mode_ack});
  endtask : do_reset

  // Holds a read request until the last two cycles of the sequence; it must not reach the pins.
  task automatic run_init(input int i);
    int p;
    int r;
    int k;
    int total;
    sdimx_pkg::sdimx_cmd_t e;
    p = pre_idle[i % 4];
    r = ref_idle[(i + 1) % 4];
    total = 2 + p + 8 * (1 + r);
    @(posedge clk_sys);
    cfg.area3_sdram <= 1'b1;
    cfg.bus32 <= (i < 4);
    cfg.precharge_idle_field <= 2'(i % 4);
    cfg.refresh_idle_field <= 2'((i + 1) % 4);
    @(posedge clk_sys);
    mode_req <= 1'b1;
    mode_addr <= MODE_WINDOW | {16'h0, mode_pat[i]};
    cmd_valid <= 1'b1;
    cmd_kind <= sdimx_pkg::SDIMX_CMD_READ;
    @(posedge clk_sys);
    mode_req <= 1'b0;
    for (int c = 1; c <= total; c++) begin
      @(posedge clk_sys);
      cmd_valid <= (c < total - 1);
      #1;
      k = c - 2 - p;
      e = (c == 1) ? sdimx_pkg::SDIMX_CMD_PRECHARGE_ALL_BANKS_CMD : (c == total) ? sdimx_pkg::SDIMX_CMD_MRS :
          (k >= 0 && k % (1 + r) == 0) ? sdimx_pkg::SDIMX_CMD_REF : sdimx_pkg::SDIMX_CMD_NOP;
      chk("command", 32'(strb(e)), 32'(seen));
      chk("mode ack", 32'(c == total), 32'(mode_ack));
      if (c == 1)
        chk("all bank pin", 32'h1, 32'(pins.addr[(i < 4) ? 12 : 11]));
      if (c < total)
        chk("ready in sequence", 32'h0, 32'(cmd_ready));
      if (c == total)
        chk("mode pins", {16'h0, mode_pat[i]}, 32'(pins.addr));
    end
    @(posedge clk_sys);
    #1;
    chk("refresh count", 32'h8, 32'(ref_count));
    chk("mode register", {16'h0, mode_pat[i]}, 32'(mode_reg));
    chk("init done", 32'h1, 32'(init_done));
  endtask : run_init

  task automatic cmd_test(input logic ap);
    sdimx_pkg::sdimx_cmd_t kinds [3] = '{sdimx_pkg::SDIMX_CMD_ACT, sdimx_pkg::SDIMX_CMD_READ,
                                         sdimx_pkg::SDIMX_CMD_WRITE};
    logic [31:0] a;
    logic [13:0] e;
    a = 32'h01b6_d35c ^ {32{ap}};
    @(posedge clk_sys);
    cfg.bus32 <= 1'b1;
    cfg.row_sel <= 2'h1;
    cfg.col_sel <= 2'h1;
    cfg.auto_precharge <= ap;
    cmd_addr <= a;
    cmd_area3 <= 1'b1;
    for (int i = 0; i <= 3; i++) begin
      @(posedge clk_sys);
      cmd_valid <= (i < 3);
      cmd_kind <= kinds[i % 3];
      #1;
      if (i == 0)
        chk("ready", 32'h1, 32'(cmd_ready));
      if (i > 0) begin
        for (int p = 2; p <= 15; p++)
          e[p-2] = (i == 1 || p >= 14) ? a[p+9] : (p == 12) ? ap : a[p];
        chk("access strobes", 32'(strb(kinds[i-1])), 32'(seen));
        chk("access address", 32'(e), 32'(pins.addr[15:2]));
      end
    end
    @(posedge clk_sys);
    #1;
    chk("after burst", 32'h1f, 32'(seen));
  endtask : cmd_test

  task automatic area_test(input logic both);
    @(posedge clk_sys);
    cfg.area2_sdram <= both;
    cmd_area3 <= 1'b0;
    cmd_kind <= sdimx_pkg::SDIMX_CMD_READ;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    chk("area 2 read", both ? 32'h0d : 32'h1f, 32'(seen));
  endtask : area_test

  initial begin
    do_reset();
    repeat (10000) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
      run_init(i);
    cmd_test(1'b0);
    cmd_test(1'b1);
    area_test(1'b0);
    area_test(1'b1);
    chk("command order", 32'h0, 32'(misorder));
    do_reset();
    print_verdict();
  end

  initial begin
    #1900000;
    bad_count++;
    print_verdict();
  end

endmodule : tb

`default_nettype wire
